// file: logic/psr_pkg.sv
/*
 * psr_pkg: constants shared by the start-of-packet mark, FIFO depth-unit,
 * wake fault counter and gigabit retrain register block.
 * Assumes a 20 MHz core clock and 16-bit management register addresses.
 */
`default_nettype none
package psr_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned MARK_UNIT_NS  = 8;

	localparam logic [15:0] ADDR_TX_MARK_DELAY  = 16'h942a;
	localparam logic [15:0] ADDR_DEPTH_UNIT     = 16'h9602;
	localparam logic [15:0] ADDR_WAKE_FAULT_CNT = 16'ha000;
	localparam logic [15:0] ADDR_GIG_RETRAIN    = 16'ha001;

	localparam int unsigned DLY10_LSB  = 8;
	localparam int unsigned DLY10_MSB  = 12;
	localparam int unsigned DLY100_LSB = 4;
	localparam int unsigned DLY100_MSB = 7;
	localparam int unsigned DLY1G_LSB  = 0;
	localparam int unsigned DLY1G_MSB  = 3;
	localparam int unsigned DEPTH_UNIT_BIT = 0;
	localparam int unsigned RETRAIN_BIT    = 0;

	localparam logic [12:0] TX_MARK_DELAY_RST = 13'h0000;
	localparam logic        DEPTH_UNIT_RST    = 1'b1;
	localparam logic [15:0] WAKE_FAULT_RST    = 16'h0000;
	localparam logic [15:0] WAKE_FAULT_MAX    = 16'hffff;
	localparam logic        GIG_RETRAIN_RST   = 1'b0;

	typedef enum logic [1:0] {
		SPD_10M  = 2'h0,
		SPD_100M = 2'h1,
		SPD_1G   = 2'h2
	} psr_speed_t;

	typedef enum logic [1:0] {
		LNK_DOWN    = 2'h0,
		LNK_UP      = 2'h1,
		LNK_RETRAIN = 2'h3
	} psr_link_t;
endpackage : psr_pkg
`default_nettype wire

// file: logic/psr_mark_delay.sv
/*
 * psr_mark_delay: delays a one-cycle start-of-packet mark by a number of
 * 8 ns units, rounded up to whole core clock cycles.
 * Assumes start_i is a single-cycle pulse synchronous to mclk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module psr_mark_delay (
	input  wire logic       mclk_i,
	input  wire logic       rst_i,
	input  wire logic       enable_i,
	input  wire logic       start_i,
	input  wire logic [4:0] units_i,
	output logic            mark_o
);
	function automatic logic [2:0] units_to_cycles(input logic [4:0] u);
		int unsigned ns;
		ns = 32'(u) * psr_pkg::MARK_UNIT_NS;
		return 3'((ns + psr_pkg::CLK_PERIOD_NS - 1) / psr_pkg::CLK_PERIOD_NS);
	endfunction : units_to_cycles

	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic       mark_nxt;
	wire  [2:0] cycles = units_to_cycles(units_i);
	wire        take   = start_i && enable_i;

	// a new mark restarts the wait; disabling drops a pending mark
	assign cnt_nxt  = !enable_i ? 3'h0 : take ? cycles : (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
	assign mark_nxt = enable_i && ((take && cycles == 3'h0) || (!take && cnt_r == 3'h1));

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_r  <= 3'h0;
			mark_o <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			mark_o <= mark_nxt;
		end
	end

	mark_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!enable_i |=> !mark_o)
		else $error("start-of-packet mark while disabled");
	mark_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		take && units_i == 5'h00 |=> mark_o)
		else $error("zero delay mark not issued next cycle");
	mark_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		take && units_i == 5'h0c ##1 (!start_i && enable_i) [*2] |=> mark_o)
		else $error("twelve unit mark not issued after two cycles");
	mark_long_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		take && units_i == 5'h14 ##[1:8] mark_o);
endmodule : psr_mark_delay
`default_nettype wire

// file: logic/psr_regs.sv
/*
 * psr_regs: transmit start-of-packet delay, MII FIFO depth unit, wake fault
 * counter and gigabit retrain control, with the link state they steer.
 * Assumes a single-cycle register read/write port from the management
 * block, and link, speed and receiver status levels from the PHY core.
 */
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - On 10 Mb links the transmit mark is delayed by bits 12:8 times 8 ns.
// - On 100 Mb links the transmit mark is delayed by bits 7:4 times 8 ns.
// - On gigabit links the transmit mark is delayed by bits 3:0 times 8 ns.
// - In MII modes the FIFO depth counts bytes when the unit bit is set, else nibbles.
// - The depth unit bit resets to one, so prefill is counted in bytes.
// - Byte counting on the nibble MII gives a larger prefill and longer latency.
// - A 16-bit counter increments on each failed low-power wake sequence, holding at 16'hffff.
// - Reading the wake fault counter returns its value and clears it.
// - With retrain on, bad gigabit receiver status retrains with link up but no data.
// - With retrain off, bad gigabit receiver status drops the link.
// - A retrain never makes the latched link status latch low.
// - The retrain enable is bit 0, read/write, one enables, reset disabled.
// - The transmit mark exists only while the mark enable is set.
module psr_regs #(
	parameter int unsigned PREFILL_UNITS = 4
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	input  wire logic [1:0]  speed_i,
	input  wire logic        mii_mode_i,
	input  wire logic        tx_packet_mark_enable_i,
	input  wire logic        tx_start_i,
	output logic             tx_start_of_packet_o,
	output logic      [7:0]  fifo_prefill_nibbles_o,
	input  wire logic        wake_fault_i,
	input  wire logic        link_ok_i,
	input  wire logic        rx_status_ok_i,
	input  wire logic        latched_status_read_i,
	output logic             link_up_o,
	output logic             data_pass_o,
	output logic             retrain_active_o,
	output logic             link_drop_o,
	output logic             latched_link_status_o
);
	logic [12:0]           tx_packet_mark_delay_r;
	logic                  fifo_depth_in_bytes_r;
	logic [15:0]           wake_fault_count_r;
	logic [15:0]           wake_fault_count_nxt;
	logic                  gigabit_retrain_enable_r;
	logic [15:0]           rdata_nxt;
	psr_pkg::psr_link_t    link_r;
	psr_pkg::psr_link_t    link_nxt;
	logic [7:0]            prefill_nxt;
	logic                  latched_nxt;

	wire hit_delay = reg_addr_i == psr_pkg::ADDR_TX_MARK_DELAY;
	wire hit_depth = reg_addr_i == psr_pkg::ADDR_DEPTH_UNIT;
	wire hit_wake  = reg_addr_i == psr_pkg::ADDR_WAKE_FAULT_CNT;
	wire hit_rtrn  = reg_addr_i == psr_pkg::ADDR_GIG_RETRAIN;
	wire wake_clr  = reg_rd_i && hit_wake;
	wire is_gig    = speed_i == psr_pkg::SPD_1G;

	// reserved bits never stored, so they read back as zero
	assign rdata_nxt = hit_delay ? {3'h0, tx_packet_mark_delay_r} :
		hit_depth ? {15'h0000, fifo_depth_in_bytes_r} :
		hit_wake  ? wake_fault_count_r :
		hit_rtrn  ? {15'h0000, gigabit_retrain_enable_r} : 16'h0000;

	// a fault in the clearing read cycle is kept as a count of one
	assign wake_fault_count_nxt = wake_clr ? {15'h0000, wake_fault_i} :
		(wake_fault_i && wake_fault_count_r != psr_pkg::WAKE_FAULT_MAX) ?
		wake_fault_count_r + 16'h0001 : wake_fault_count_r;

	// per-speed delay selection
	wire [4:0] d10  = tx_packet_mark_delay_r[psr_pkg::DLY10_MSB:psr_pkg::DLY10_LSB];
	wire [3:0] d100 = tx_packet_mark_delay_r[psr_pkg::DLY100_MSB:psr_pkg::DLY100_LSB];
	wire [3:0] d1g  = tx_packet_mark_delay_r[psr_pkg::DLY1G_MSB:psr_pkg::DLY1G_LSB];
	wire [4:0] delay_units = (speed_i == psr_pkg::SPD_10M)  ? d10 :
		(speed_i == psr_pkg::SPD_100M) ? {1'b0, d100} : {1'b0, d1g};

	// byte counting doubles the nibble prefill on MII, at a latency cost
	wire [7:0] prefill_base = 8'(PREFILL_UNITS);
	assign prefill_nxt = (mii_mode_i && fifo_depth_in_bytes_r) ?
		8'(prefill_base << 1) : prefill_base;

	always_comb
	begin
		link_nxt = link_r;
		case (link_r)
			psr_pkg::LNK_DOWN:
				if (link_ok_i)
					link_nxt = psr_pkg::LNK_UP;
			psr_pkg::LNK_UP:
				if (!link_ok_i)
					link_nxt = psr_pkg::LNK_DOWN;
				else if (is_gig && !rx_status_ok_i)
					link_nxt = gigabit_retrain_enable_r ? psr_pkg::LNK_RETRAIN
						: psr_pkg::LNK_DOWN;
			psr_pkg::LNK_RETRAIN:
				if (!link_ok_i)
					link_nxt = psr_pkg::LNK_DOWN;
				else if (rx_status_ok_i)
					link_nxt = psr_pkg::LNK_UP;
			default:
				link_nxt = psr_pkg::LNK_DOWN;
		endcase
	end

	// only a true drop latches low; a drop beats a read in the same cycle
	wire going_down = link_r != psr_pkg::LNK_DOWN && link_nxt == psr_pkg::LNK_DOWN;
	assign latched_nxt = going_down ? 1'b0 :
		latched_status_read_i ? (link_nxt != psr_pkg::LNK_DOWN) : latched_link_status_o;

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_packet_mark_delay_r   <= psr_pkg::TX_MARK_DELAY_RST;
			fifo_depth_in_bytes_r    <= psr_pkg::DEPTH_UNIT_RST;
			wake_fault_count_r       <= psr_pkg::WAKE_FAULT_RST;
			gigabit_retrain_enable_r <= psr_pkg::GIG_RETRAIN_RST;
			reg_rdata_o              <= 16'h0000;
			link_r                   <= psr_pkg::LNK_DOWN;
			link_drop_o              <= 1'b0;
			latched_link_status_o    <= 1'b0;
			fifo_prefill_nibbles_o   <= 8'h00;
		end
		else
		begin
			if (reg_wr_i && hit_delay)
				tx_packet_mark_delay_r <= reg_wdata_i[12:0];
			if (reg_wr_i && hit_depth)
				fifo_depth_in_bytes_r <= reg_wdata_i[psr_pkg::DEPTH_UNIT_BIT];
			if (reg_wr_i && hit_rtrn)
				gigabit_retrain_enable_r <= reg_wdata_i[psr_pkg::RETRAIN_BIT];
			if (reg_rd_i)
				reg_rdata_o <= rdata_nxt;
			wake_fault_count_r     <= wake_fault_count_nxt;
			link_r                 <= link_nxt;
			link_drop_o            <= going_down;
			latched_link_status_o  <= latched_nxt;
			fifo_prefill_nibbles_o <= prefill_nxt;
		end
	end

	assign link_up_o        = link_r != psr_pkg::LNK_DOWN;
	assign data_pass_o      = link_r == psr_pkg::LNK_UP;
	assign retrain_active_o = link_r == psr_pkg::LNK_RETRAIN;

	psr_mark_delay u_mark (
		.mclk_i   (mclk_i),
		.rst_i    (rst_i),
		.enable_i (tx_packet_mark_enable_i),
		.start_i  (tx_start_i),
		.units_i  (delay_units),
		.mark_o   (tx_start_of_packet_o)
	);

	wake_count_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		wake_fault_i && !wake_clr && wake_fault_count_r != 16'hffff
		|=> wake_fault_count_r == $past(wake_fault_count_r) + 16'h0001)
		else $error("wake fault not counted");
	wake_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		wake_clr |=> reg_rdata_o == $past(wake_fault_count_r)
		&& wake_fault_count_r == {15'h0000, $past(wake_fault_i)})
		else $error("wake counter read did not return and clear");
	depth_unit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		mii_mode_i && fifo_depth_in_bytes_r
		|=> fifo_prefill_nibbles_o == 8'(2 * PREFILL_UNITS))
		else $error("byte depth prefill wrong");
	retrain_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		link_r == psr_pkg::LNK_UP && link_ok_i && is_gig && !rx_status_ok_i
		&& gigabit_retrain_enable_r |=> link_up_o && !data_pass_o && retrain_active_o)
		else $error("retrain did not hold link up without data");
	drop_link_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		link_r == psr_pkg::LNK_UP && is_gig && !rx_status_ok_i
		&& !gigabit_retrain_enable_r |=> !link_up_o && link_drop_o)
		else $error("link not dropped with retrain off");
	latch_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		retrain_active_o && link_ok_i |=> !$fell(latched_link_status_o))
		else $error("retrain latched link status low");
	retrain_bit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		reg_wr_i && hit_rtrn ##1 reg_rd_i && hit_rtrn
		|=> reg_rdata_o == {15'h0000, $past(reg_wdata_i[0], 2)})
		else $error("retrain enable readback wrong");
	reserved_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		reg_rd_i && hit_delay |=> reg_rdata_o[15:13] == 3'h0)
		else $error("reserved bits not zero");

	retrain_back_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		retrain_active_o ##[1:20] data_pass_o);
	wake_clear_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		wake_clr && wake_fault_i);
	drop_c: cover property (@(posedge mclk_i) disable iff (rst_i) link_drop_o);
endmodule : psr_regs
`default_nettype wire

// file: test/psr_far_end.sv
/*
 * psr_far_end: behavioural stand-in for the MAC and the link partner side.
 * Assumes the bench commands it one edge ahead; it answers on the next edge.
 */
`timescale 1ns/10ps
`default_nettype none
module psr_far_end (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic send_i,
	input  wire logic link_cmd_i,
	input  wire logic rx_ok_cmd_i,
	output logic      tx_start_o,
	output logic      link_ok_o,
	output logic      rx_status_ok_o
);
	// registered so every change lands just after a rising edge
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tx_start_o     <= 1'b0;
			link_ok_o      <= 1'b0;
			rx_status_ok_o <= 1'b0;
		end
		else
		begin
			tx_start_o     <= send_i;
			link_ok_o      <= link_cmd_i;
			rx_status_ok_o <= rx_ok_cmd_i;
		end
	end
endmodule : psr_far_end
`default_nettype wire

// file: test/phy_sop_fifo_eee_retrain_regs_tb_top.sv
/*
 * phy_sop_fifo_eee_retrain_regs_tb_top: self-checking bench for psr_regs.
 * Assumes the far-end model adds one cycle to every command.
 */
`timescale 1ns/10ps
`default_nettype none
module phy_sop_fifo_eee_retrain_regs_tb_top;
	typedef struct packed { logic [1:0] spd; logic [15:0] dly; int lat; } psr_tb_row_t;
	logic        mclk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, mii = 1'b1, en = 1'b1;
	logic        send = 1'b0, lcmd = 1'b0, rcmd = 1'b0, wf = 1'b0, lsr = 1'b0;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
	logic [1:0]  spd = 2'h0;
	logic [7:0]  prefill;
	logic        start, mark, lok, rok, up, pass, rtr, drop, latched;
	int          error_cnt = 0, tests_run = 0, n;
	psr_tb_row_t rows [9] = '{'{2'h0, 16'h1400, 5}, '{2'h1, 16'h0000, 1}, '{2'h2, 16'h0006, 2},
		'{2'h0, 16'h1f00, 6}, '{2'h1, 16'h00f0, 4}, '{2'h2, 16'h000f, 4}, '{2'h1, 16'h1f0f, 1},
		'{2'h2, 16'h000c, 3}, '{2'h3, 16'h0c01, 2}};

	initial forever #25 mclk_i = ~mclk_i;

	psr_far_end far (.mclk_i(mclk_i), .rst_i(rst_i), .send_i(send), .link_cmd_i(lcmd),
		.rx_ok_cmd_i(rcmd), .tx_start_o(start), .link_ok_o(lok), .rx_status_ok_o(rok));

	psr_regs uut (.mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .speed_i(spd),
		.mii_mode_i(mii), .tx_packet_mark_enable_i(en), .tx_start_i(start),
		.tx_start_of_packet_o(mark), .fifo_prefill_nibbles_o(prefill), .wake_fault_i(wf),
		.link_ok_i(lok), .rx_status_ok_i(rok), .latched_status_read_i(lsr),
		.link_up_o(up), .data_pass_o(pass), .retrain_active_o(rtr), .link_drop_o(drop),
		.latched_link_status_o(latched));

	task automatic tally_and_finish;
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask : check

	task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk_i) {addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge mclk_i) wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge mclk_i) {addr, rd} <= {a, 1'b1};
		@(posedge mclk_i) rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_rd

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] d;
		reg_rd(a, d);
		check(d, exp);
	endtask : rd_chk

	task automatic settle(input int c);
		repeat (c) @(posedge mclk_i);
		#1;
	endtask : settle

	// edges from the far end's start pulse to the delayed mark, bounded
	task automatic fire_mark(input logic [1:0] s, input logic [15:0] d, input int lat);
		@(posedge mclk_i) spd <= s;
		reg_wr(psr_pkg::ADDR_TX_MARK_DELAY, d);
		@(posedge mclk_i) send <= 1'b1;
		@(posedge mclk_i) send <= 1'b0;
		#1 n = 0;
		while (n < 12 && mark !== 1'b1)
		begin
			@(posedge mclk_i);
			#1 n++;
		end
		check(16'(n), 16'(lat));
		if (n >= 12)
			tally_and_finish();
		else
			settle(8);
	endtask : fire_mark

	initial
	begin
		settle(20);
		rst_i <= 1'b0;
		settle(2);
		check(16'(prefill), 16'(2 * 4));
		rd_chk(psr_pkg::ADDR_TX_MARK_DELAY, 16'h0000);
		rd_chk(psr_pkg::ADDR_DEPTH_UNIT, 16'h0001);
		rd_chk(psr_pkg::ADDR_WAKE_FAULT_CNT, 16'h0000);
		rd_chk(psr_pkg::ADDR_GIG_RETRAIN, 16'h0000);
		reg_wr(psr_pkg::ADDR_TX_MARK_DELAY, 16'hffff);
		rd_chk(psr_pkg::ADDR_TX_MARK_DELAY, 16'h1fff);
		reg_wr(psr_pkg::ADDR_GIG_RETRAIN, 16'hfffe);
		rd_chk(psr_pkg::ADDR_GIG_RETRAIN, 16'h0000);
		reg_wr(16'h9429, 16'hffff);
		rd_chk(16'h9429, 16'h0000);
		for (int i = 0; i < 9; i++)
			fire_mark(rows[i].spd, rows[i].dly, rows[i].lat);
		// start ignored while the mark is disabled
		en <= 1'b0;
		@(posedge mclk_i) send <= 1'b1;
		@(posedge mclk_i) send <= 1'b0;
		repeat (6)
		begin
			settle(1);
			check(16'(mark), 16'h0000);
		end
		reg_wr(psr_pkg::ADDR_DEPTH_UNIT, 16'hfffe);
		rd_chk(psr_pkg::ADDR_DEPTH_UNIT, 16'h0000);
		settle(2);
		check(16'(prefill), 16'(4));
		// outside MII the byte unit must not enlarge the prefill
		@(posedge mclk_i) mii <= 1'b0;
		reg_wr(psr_pkg::ADDR_DEPTH_UNIT, 16'h0001);
		settle(2);
		check(16'(prefill), 16'(4));
		@(posedge mclk_i) mii <= 1'b1;
		settle(2);
		check(16'(prefill), 16'(2 * 4));
		repeat (3)
		begin
			@(posedge mclk_i) wf <= 1'b1;
			@(posedge mclk_i) wf <= 1'b0;
		end
		rd_chk(psr_pkg::ADDR_WAKE_FAULT_CNT, 16'h0003);
		rd_chk(psr_pkg::ADDR_WAKE_FAULT_CNT, 16'h0000);
		// fault in the clearing read cycle survives as a count of one
		@(posedge mclk_i) {addr, rd, wf} <= {psr_pkg::ADDR_WAKE_FAULT_CNT, 1'b1, 1'b1};
		@(posedge mclk_i) {rd, wf} <= 2'b00;
		#1 check(rdata, 16'h0000);
		rd_chk(psr_pkg::ADDR_WAKE_FAULT_CNT, 16'h0001);
		@(posedge mclk_i) {spd, lcmd, rcmd} <= {2'h2, 1'b1, 1'b1};
		settle(4);
		@(posedge mclk_i) lsr <= 1'b1;
		@(posedge mclk_i) lsr <= 1'b0;
		// back-to-back write then read of the retrain enable
		@(posedge mclk_i) {addr, wdata, wr} <= {psr_pkg::ADDR_GIG_RETRAIN, 16'h0001, 1'b1};
		@(posedge mclk_i) {wr, rd} <= 2'b01;
		@(posedge mclk_i) rd <= 1'b0;
		#1 check(rdata, 16'h0001);
		check(16'({up, pass, rtr, latched}), 16'hd);
		@(posedge mclk_i) rcmd <= 1'b0;
		settle(4);
		check(16'({up, pass, rtr, latched}), 16'hb);
		@(posedge mclk_i) rcmd <= 1'b1;
		settle(4);
		check(16'({up, pass, rtr}), 16'h6);
		reg_wr(psr_pkg::ADDR_GIG_RETRAIN, 16'h0000);
		@(posedge mclk_i) rcmd <= 1'b0;
		#1 n = 0;
		while (n < 8 && up !== 1'b0)
		begin
			settle(1);
			n++;
		end
		check(16'(latched), 16'h0000);
		check(16'(drop), 16'h0001);
		check(16'(n < 8), 16'h0001);
		settle(1);
		check(16'(drop), 16'h0000);
		reg_wr(psr_pkg::ADDR_GIG_RETRAIN, 16'h0001);
		// mid-run reset must bring registers and link state back to defaults
		@(posedge mclk_i) {lcmd, rst_i} <= 2'b01;
		settle(2);
		check(16'({prefill, up, pass, rtr, drop, latched, mark}), 16'h0000);
		@(posedge mclk_i) rst_i <= 1'b0;
		settle(2);
		rd_chk(psr_pkg::ADDR_TX_MARK_DELAY, 16'h0000);
		rd_chk(psr_pkg::ADDR_GIG_RETRAIN, 16'h0000);
		rd_chk(psr_pkg::ADDR_DEPTH_UNIT, 16'h0001);
		tally_and_finish();
	end
endmodule : phy_sop_fifo_eee_retrain_regs_tb_top
`default_nettype wire
